// [inc/sods_consts.vh]
// Constants for the speaker output diagnostic sequencer.
// Summary of operation
// - On host request, leaving stand-by runs a load test for shorts and open load.
// - Turn-on result is held until a host read requests a new test pulse.
// - Stand-by exit plus diag enable together: pulse first, outputs high-Z, then bias.
// - Once biased, permanent diagnostics run; turn-on result stays until a short appears.
// - Output status is latched at the end of the 100 ms test pulse plateau.
// - Shorted/open load thresholds use line-driver values only at 12 dB and line mode.
// - Restart mode: only the faulted channel stops, rechecked every 1 ms, resumes when clear.
// - Diagnostic mode is enabled by the host and self-starts on a protection trip; the code ignores diag enable here, as that bit gates only the turn-on test.
// - After a trip, recheck 1 ms later; no overload means the channel resumes.
// - Overload still present at the recheck starts a 100 ms diagnostic cycle.
// - Cycle end puts the channel in restart mode, stores results; next cycle after read.
// - A DC output offset beyond about 2 V is flagged.
// - Offset window opens at the previous read or offset enable, closes at this read.
// - Offset is reported only if it holds for the whole window.
// - A protection trip during the test suppresses the offset and AC current results.
// - Peak current above 500 mA is normal; below 250 mA is an open tweeter.
// - Fewer than 3 pulses above 500 mA in the period report an open tweeter.
// - With several faults, one is reported first; the rest after reads and removal.
// - Double faults resolve by priority: supply short, feed ground, drain ground rules.
// - Permanent diagnostics never report open load; only a turn-on test does.
// - Each read returns the previous cycle's results and restarts all cycles.
// - The offset enable bit of the first instruction byte enables offset detection.
// - Cycle-terminated flag is 1 after a completed cycle, else 0.
`ifndef SODS_CONSTS_VH
`define SODS_CONSTS_VH

`define SODS_CLK_HZ        10000000
`define SODS_T_RECHECK_US  1000
`define SODS_T_CYCLE_MS    100
`define SODS_AC_PULSES     2'h3

`define SODS_ADDR_CTRL     8'h00
`define SODS_ADDR_DIAG     8'h04
`define SODS_ADDR_STAT     8'h08
`define SODS_CTRL_RESET    16'h0000

`define SODS_BIT_DIAG_EN   6
`define SODS_BIT_OFFSET_EN 5
`define SODS_BIT_GAIN_F    4
`define SODS_BIT_GAIN_R    3
`define SODS_BIT_STBY_OFF  12
`define SODS_BIT_LINE_MODE 11
`define SODS_BIT_CUR_EN    10

`endif

// [src/sods_chan.v]
// One channel: turn-on latch, permanent diagnostic, restart and fault priority.
`timescale 1ns/10ps
module sods_chan #(
    parameter FEED_POS    = 1,
    parameter RECHECK_CYC = 10000,
    parameter CYCLE_CYC   = 1000000
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       gnd_p,
    input  wire       gnd_n,
    input  wire       vs,
    input  wire       sload,
    input  wire       open,
    input  wire       trip,
    input  wire       arm,
    input  wire       ton_strobe,
    output wire       active,
    output wire       rstmode,
    output reg        done,
    output wire [4:0] flags
);
    localparam [1:0] ST_RUN = 2'h0, ST_WAIT = 2'h1, ST_DIAG = 2'h2, ST_RSTR = 2'h3;
    localparam [19:0] RECHECK_LD = RECHECK_CYC[19:0] - 20'h00001;
    localparam [19:0] CYCLE_LD   = CYCLE_CYC[19:0] - 20'h00001;

    reg  [1:0]  state_reg;
    reg  [19:0] cnt_reg;
    reg         armed_reg;
    reg  [3:0]  acc_reg;
    reg  [3:0]  res_reg;
    reg         perm_reg;
    wire        gnd_feed  = FEED_POS ? gnd_p : gnd_n;
    wire        gnd_drain = FEED_POS ? gnd_n : gnd_p;
    wire        overload  = trip | gnd_p | gnd_n | vs | sload;

    // Result bits: [3] shorted load, [2] open load, [1] supply short, [0] ground short.
    function [3:0] resolve;
        input gf;
        input gd;
        input v;
        input sl;
        input op;
        input allow_open;
        begin
            resolve = 4'h0;
            if (v) begin
                resolve = {2'h0, 1'b1, gf};
            end else if (gf) begin
                resolve = 4'h1;
            end else if (gd) begin
                resolve = (op & allow_open) ? 4'h4 : 4'h1;
            end else if (sl) begin
                resolve = 4'h8;
            end else if (op & allow_open) begin
                resolve = 4'h4;
            end
        end
    endfunction

    assign active  = (state_reg == ST_RUN);
    assign rstmode = (state_reg == ST_RSTR);
    assign flags   = {perm_reg, res_reg};

    always @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_RUN;
            cnt_reg   <= 20'h00000;
            armed_reg <= 1'b1;
            acc_reg   <= 4'h0;
            res_reg   <= 4'h0;
            perm_reg  <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (ton_strobe) begin
                res_reg  <= resolve(gnd_feed, gnd_drain, vs, sload, open, 1'b1);
                perm_reg <= 1'b0;
            end
            case (state_reg)
                ST_RUN: begin
                    if (trip) begin
                        cnt_reg   <= RECHECK_LD;
                        state_reg <= armed_reg ? ST_WAIT : ST_RSTR;
                    end
                end
                ST_WAIT: begin
                    if (cnt_reg == 20'h00000) begin
                        if (overload) begin
                            cnt_reg   <= CYCLE_LD;
                            acc_reg   <= 4'hf;
                            state_reg <= ST_DIAG;
                        end else begin
                            state_reg <= ST_RUN;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 20'h00001;
                    end
                end
                ST_DIAG: begin
                    // A fault must be present for the whole cycle to be reported.
                    acc_reg <= acc_reg & {sload, vs, gnd_drain, gnd_feed};
                    if (cnt_reg == 20'h00000) begin
                        res_reg   <= resolve(acc_reg[0], acc_reg[1], acc_reg[2],
                                             acc_reg[3], 1'b0, 1'b0);
                        perm_reg  <= 1'b1;
                        done      <= 1'b1;
                        cnt_reg   <= RECHECK_LD;
                        state_reg <= ST_RSTR;
                    end else begin
                        cnt_reg <= cnt_reg - 20'h00001;
                    end
                end
                ST_RSTR: begin
                    if (cnt_reg == 20'h00000) begin
                        cnt_reg <= RECHECK_LD;
                        if (!overload) begin
                            state_reg <= ST_RUN;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 20'h00001;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
            if (state_reg == ST_DIAG && cnt_reg == 20'h00000) begin
                armed_reg <= 1'b0;
            end
            if (arm) begin
                armed_reg <= 1'b1;
            end
        end
    end
endmodule

// [src/sods_top.v]
// Top of the speaker output diagnostic sequencer with its APB register slave.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "sods_consts.vh"
module sods_top #(
    parameter RECHECK_CYC = `SODS_T_RECHECK_US * (`SODS_CLK_HZ / 1000000),
    parameter CYCLE_CYC   = `SODS_T_CYCLE_MS * (`SODS_CLK_HZ / 1000)
) (
    input  wire        CLK_SYS,
    input  wire        RST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire [3:0]  CMP_GND_P,
    input  wire [3:0]  CMP_GND_N,
    input  wire [3:0]  CMP_VS,
    input  wire [3:0]  CMP_SLOAD,
    input  wire [3:0]  CMP_OPEN,
    input  wire [3:0]  CMP_OFFSET,
    input  wire [3:0]  CMP_CUR_HI,
    input  wire [3:0]  PROT_TRIP,
    output wire [3:0]  CH_ACTIVE,
    output wire        TEST_PULSE,
    output wire        OUT_HIZ,
    output wire        PWR_BIAS,
    output reg  [3:0]  LINE_THR
);
    // ------------------------------------------------------------------
    // Local definitions
    // ------------------------------------------------------------------
    localparam [1:0]  TS_STBY  = 2'h0;
    localparam [1:0]  TS_PULSE = 2'h1;
    localparam [1:0]  TS_BIAS  = 2'h2;
    localparam [19:0] CYCLE_LD = CYCLE_CYC[19:0] - 20'h00001;

    function hit;
        input [7:0] addr;
        input [7:0] offs;
        begin
            hit = (addr == offs);
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Comparator outputs are analog-domain levels; a change is accepted once
    // the second and third stages agree, which rejects single-cycle glitches.
    wire [31:0] pin_raw = {PROT_TRIP, CMP_CUR_HI, CMP_OFFSET, CMP_OPEN,
                           CMP_SLOAD, CMP_VS, CMP_GND_N, CMP_GND_P};
    reg  [31:0] sy1_reg;
    reg  [31:0] sy2_reg;
    reg  [31:0] sy3_reg;
    reg  [31:0] filt_reg;
    wire [31:0] filt_next = (sy2_reg & sy3_reg) | (filt_reg & (sy2_reg ^ sy3_reg));

    always @(posedge CLK_SYS) begin
        if (RST) begin
            sy1_reg  <= 32'h00000000;
            sy2_reg  <= 32'h00000000;
            sy3_reg  <= 32'h00000000;
            filt_reg <= 32'h00000000;
        end else begin
            sy1_reg  <= pin_raw;
            sy2_reg  <= sy1_reg;
            sy3_reg  <= sy2_reg;
            filt_reg <= filt_next;
        end
    end

    wire [3:0] f_gnd_p  = filt_reg[3:0];
    wire [3:0] f_gnd_n  = filt_reg[7:4];
    wire [3:0] f_vs     = filt_reg[11:8];
    wire [3:0] f_sload  = filt_reg[15:12];
    wire [3:0] f_open   = filt_reg[19:16];
    wire [3:0] f_offset = filt_reg[23:20];
    wire [3:0] f_cur    = filt_reg[27:24];
    wire [3:0] f_trip   = filt_reg[31:28];

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    reg  [15:0] ctrl_reg;
    reg  [31:0] report_reg;
    reg         done_reg;
    wire        mapped  = hit(PADDR, `SODS_ADDR_CTRL) |
                          (!PWRITE & (hit(PADDR, `SODS_ADDR_DIAG) |
                                      hit(PADDR, `SODS_ADDR_STAT)));
    wire        acc     = PSEL & PENABLE;
    wire        wr_ctrl = acc & PWRITE & hit(PADDR, `SODS_ADDR_CTRL);
    wire        rd_diag = acc & !PWRITE & hit(PADDR, `SODS_ADDR_DIAG);
    wire [31:0] stat_word;

    assign PREADY  = 1'b1;
    assign PSLVERR = acc & !mapped;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_reg <= `SODS_CTRL_RESET;
            PRDATA   <= 32'h00000000;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= PWDATA[15:0];
            end
            // Read data is captured in the setup cycle, so a diagnostic read
            // returns the snapshot taken by the previous read.
            if (PSEL && !PENABLE && !PWRITE) begin
                if (hit(PADDR, `SODS_ADDR_CTRL)) begin
                    PRDATA <= {16'h0000, ctrl_reg};
                end else if (hit(PADDR, `SODS_ADDR_DIAG)) begin
                    PRDATA <= report_reg;
                end else if (hit(PADDR, `SODS_ADDR_STAT)) begin
                    PRDATA <= stat_word;
                end else begin
                    PRDATA <= 32'h00000000;
                end
            end
        end
    end

    wire diag_en   = ctrl_reg[`SODS_BIT_DIAG_EN];
    wire offset_en = ctrl_reg[`SODS_BIT_OFFSET_EN];
    wire stby_off  = ctrl_reg[`SODS_BIT_STBY_OFF];
    wire line_mode = ctrl_reg[`SODS_BIT_LINE_MODE];
    wire cur_en    = ctrl_reg[`SODS_BIT_CUR_EN];

    // Channel order: 0 left front, 1 right front, 2 left rear, 3 right rear.
    always @(posedge CLK_SYS) begin
        if (RST) begin
            LINE_THR <= 4'h0;
        end else begin
            LINE_THR[0] <= line_mode & ctrl_reg[`SODS_BIT_GAIN_F];
            LINE_THR[1] <= line_mode & ctrl_reg[`SODS_BIT_GAIN_F];
            LINE_THR[2] <= line_mode & ctrl_reg[`SODS_BIT_GAIN_R];
            LINE_THR[3] <= line_mode & ctrl_reg[`SODS_BIT_GAIN_R];
        end
    end

    // ------------------------------------------------------------------
    // Turn-on test sequencer
    // ------------------------------------------------------------------
    reg  [1:0]  ts_reg;
    reg  [19:0] tcnt_reg;
    reg         test_req_reg;
    reg         ton_strobe;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            ts_reg       <= TS_STBY;
            tcnt_reg     <= 20'h00000;
            test_req_reg <= 1'b1;
            ton_strobe   <= 1'b0;
        end else begin
            ton_strobe <= 1'b0;
            case (ts_reg)
                TS_STBY: begin
                    if (stby_off) begin
                        if (diag_en && test_req_reg) begin
                            tcnt_reg <= CYCLE_LD;
                            ts_reg   <= TS_PULSE;
                        end else begin
                            ts_reg <= TS_BIAS;
                        end
                    end
                end
                TS_PULSE: begin
                    if (!stby_off) begin
                        ts_reg <= TS_STBY;
                    end else if (tcnt_reg == 20'h00000) begin
                        ton_strobe <= 1'b1;
                        ts_reg     <= TS_BIAS;
                    end else begin
                        tcnt_reg <= tcnt_reg - 20'h00001;
                    end
                end
                TS_BIAS: begin
                    if (!stby_off) begin
                        ts_reg <= TS_STBY;
                    end
                end
                default: begin
                    ts_reg <= TS_STBY;
                end
            endcase
            if (ts_reg == TS_PULSE && stby_off && tcnt_reg == 20'h00000) begin
                test_req_reg <= 1'b0;
            end
            if (rd_diag) begin
                test_req_reg <= 1'b1;
            end
        end
    end

    assign TEST_PULSE = (ts_reg == TS_PULSE);
    assign OUT_HIZ    = (ts_reg != TS_BIAS);
    assign PWR_BIAS   = (ts_reg == TS_BIAS);

    // ------------------------------------------------------------------
    // Channels, offset window and AC current counting
    // ------------------------------------------------------------------
    wire [3:0]  ch_active;
    wire [3:0]  ch_rst;
    wire [3:0]  ch_done;
    wire [19:0] ch_flags;
    wire [31:0] live_word;
    reg         offen_d_reg;
    reg         curen_d_reg;
    wire        off_start = rd_diag | (offset_en & !offen_d_reg);
    wire        ac_start  = rd_diag | (cur_en & !curen_d_reg);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ch
            reg        off_ok_reg;
            reg        ac_sup_reg;
            reg  [1:0] ac_cnt_reg;
            reg        cur_d_reg;
            wire       off_flag = offset_en & off_ok_reg;
            wire       open_tw  = cur_en & !ac_sup_reg &
                                  (ac_cnt_reg != `SODS_AC_PULSES);

            sods_chan #(
                .FEED_POS    ((g == 0 || g == 3) ? 1 : 0),
                .RECHECK_CYC (RECHECK_CYC),
                .CYCLE_CYC   (CYCLE_CYC)
            ) u_chan (
                .clk        (CLK_SYS),
                .rst        (RST),
                .gnd_p      (f_gnd_p[g]),
                .gnd_n      (f_gnd_n[g]),
                .vs         (f_vs[g]),
                .sload      (f_sload[g]),
                .open       (f_open[g]),
                .trip       (f_trip[g] & PWR_BIAS),
                .arm        (rd_diag),
                .ton_strobe (ton_strobe),
                .active     (ch_active[g]),
                .rstmode    (ch_rst[g]),
                .done       (ch_done[g]),
                .flags      (ch_flags[5*g+4:5*g])
            );

            assign live_word[8*g+7:8*g] = {1'b0, done_reg, open_tw, ch_flags[5*g+4],
                                           ch_flags[5*g+3],
                                           ch_flags[5*g+2] | off_flag,
                                           ch_flags[5*g+1], ch_flags[5*g]};

            always @(posedge CLK_SYS) begin
                if (RST) begin
                    off_ok_reg <= 1'b0;
                    ac_sup_reg <= 1'b0;
                    ac_cnt_reg <= 2'h0;
                    cur_d_reg  <= 1'b0;
                end else begin
                    cur_d_reg <= f_cur[g];
                    if (off_start) begin
                        off_ok_reg <= 1'b1;
                    end else begin
                        off_ok_reg <= off_ok_reg & f_offset[g] & !f_trip[g];
                    end
                    if (ac_start) begin
                        // A trip in the restart cycle still counts, so the set wins.
                        ac_sup_reg <= f_trip[g];
                        ac_cnt_reg <= 2'h0;
                    end else begin
                        if (f_trip[g]) begin
                            ac_sup_reg <= 1'b1;
                        end
                        if (f_cur[g] && !cur_d_reg && ac_cnt_reg != `SODS_AC_PULSES) begin
                            ac_cnt_reg <= ac_cnt_reg + 2'h1;
                        end
                    end
                end
            end
        end
    endgenerate

    assign CH_ACTIVE = ch_active & {4{PWR_BIAS}};
    assign stat_word = {16'h0000, 4'h0, ch_rst, 4'h0, PWR_BIAS, TEST_PULSE,
                        test_req_reg, done_reg};

    // ------------------------------------------------------------------
    // Cycle-done flag and read snapshot
    // ------------------------------------------------------------------
    // The snapshot is taken at the read itself and shown at the next read,
    // so a change in the outputs needs two reads to become visible.
    always @(posedge CLK_SYS) begin
        if (RST) begin
            done_reg    <= 1'b0;
            report_reg  <= 32'h00000000;
            offen_d_reg <= 1'b0;
            curen_d_reg <= 1'b0;
        end else begin
            offen_d_reg <= offset_en;
            curen_d_reg <= cur_en;
            if (rd_diag) begin
                report_reg <= live_word;
                done_reg   <= 1'b0;
            end
            if (ton_strobe || ch_done != 4'h0) begin
                done_reg <= 1'b1;
            end
        end
    end
endmodule

// [tb/sods_host.sv]
// Host model: APB master standing in for the controlling processor.
`timescale 1ns/10ps
module sods_host (
    input  wire        clk,
    input  wire        pready,
    input  wire [31:0] prdata,
    input  wire        pslverr,
    output reg         psel    = 1'b0,
    output reg         penable = 1'b0,
    output reg         pwrite  = 1'b0,
    output reg  [7:0]  paddr   = 8'h00,
    output reg  [31:0] pwdata  = 32'h0
);

    // The whole request is held until pready is seen high at an edge.
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule

// [tb/sods_top_properties.sv]
// Concurrent checks on the ports of the diagnostic sequencer top.
`timescale 1ns/10ps
module sods_top_properties #(
    parameter RECHECK_CYC = 10000,
    parameter CYCLE_CYC   = 1000000
) (
    input wire        CLK_SYS,
    input wire        RST,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [7:0]  PADDR,
    input wire [31:0] PWDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire [3:0]  PROT_TRIP,
    input wire [3:0]  CH_ACTIVE,
    input wire        TEST_PULSE,
    input wire        OUT_HIZ,
    input wire        PWR_BIAS,
    input wire [3:0]  LINE_THR
);
    reg  [15:0] ctrl_reg;
    reg  [31:0] pulse_reg;
    wire        bad = PADDR > 8'h08 || PADDR[1:0] != 2'h0 || (PWRITE && PADDR != 8'h00);
    wire [3:0]  thr = ctrl_reg[11] ? {{2{ctrl_reg[3]}}, {2{ctrl_reg[4]}}} : 4'h0;

    always @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl_reg <= 16'h0000;
            pulse_reg <= 32'h0;
        end else begin
            if (PSEL && PENABLE && PWRITE && PADDR == 8'h00)
                ctrl_reg <= PWDATA[15:0];
            pulse_reg <= TEST_PULSE ? pulse_reg + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_wake;
        PSEL && PENABLE && PWRITE && PADDR == 8'h00 && PWDATA[12] && OUT_HIZ && !TEST_PULSE;
    endsequence
    sequence s_stuck;
        ((PROT_TRIP & CH_ACTIVE) != 4'h0) [*8];
    endsequence

    a_wake_pulse: assert property (s_wake ##0 PWDATA[6] |-> ##[1:4] (TEST_PULSE || PWR_BIAS))
        else $error("no pulse or bias after wake");
    a_wake_bias: assert property (s_wake ##0 !PWDATA[6] |-> ##[1:4] (PWR_BIAS && !TEST_PULSE))
        else $error("wake without diag did not bias");
    a_pulse_hiz: assert property (TEST_PULSE |-> OUT_HIZ && !PWR_BIAS)
        else $error("outputs not high-Z during pulse");
    a_stby_hiz: assert property (PSEL && PENABLE && PWRITE && !PWDATA[12] && PADDR == 8'h00
        |-> ##[1:4] (OUT_HIZ && !TEST_PULSE))
        else $error("stand-by write left outputs driven");
    a_pulse_bound: assert property (TEST_PULSE |-> pulse_reg <= CYCLE_CYC)
        else $error("test pulse too long");
    a_pulse_len: assert property ($fell(TEST_PULSE) && PWR_BIAS |-> pulse_reg + 1 >= CYCLE_CYC)
        else $error("test pulse too short");
    a_active_bias: assert property (CH_ACTIVE != 4'h0 |-> PWR_BIAS)
        else $error("channel active while unbiased");
    a_trip_stops: assert property (s_stuck |-> 1'b0)
        else $error("tripped channel kept playing");
    a_line_thr: assert property (ctrl_reg == $past(ctrl_reg, 2) |-> LINE_THR == thr)
        else $error("line threshold select wrong");
    a_bus_refuse: assert property (PREADY && PSLVERR == (PSEL && PENABLE && bad))
        else $error("bus response wrong");
endmodule

bind sods_top sods_top_properties #(.RECHECK_CYC(RECHECK_CYC), .CYCLE_CYC(CYCLE_CYC))
    sods_top_properties_inst (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PROT_TRIP(PROT_TRIP), .CH_ACTIVE(CH_ACTIVE), .TEST_PULSE(TEST_PULSE),
    .OUT_HIZ(OUT_HIZ), .PWR_BIAS(PWR_BIAS), .LINE_THR(LINE_THR));

// [tb/sods_top_test.sv]
// Self-checking testbench of the diagnostic sequencer.
`timescale 1ns/10ps
module sods_top_test;
    localparam RCHK = 20;
    localparam CYC  = 50;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    wire        psel, penable, pwrite, pready, pslverr, pulse, hiz, bias;
    wire [7:0]  paddr;
    wire [31:0] pwdata, prdata;
    wire [3:0]  act, thr;
    reg  [3:0]  gp = 4'h0, gn = 4'h0, vs = 4'h0, sl = 4'h0, op = 4'h0;
    reg  [3:0]  ofs = 4'h0, cur = 4'h0, trip = 4'h0;
    reg  [31:0] q;
    reg         err;
    integer     fail_count = 0, check_count = 0, i;

    always #50 clk = ~clk;

    sods_top #(.RECHECK_CYC(RCHK), .CYCLE_CYC(CYC)) sods_top_inst (.CLK_SYS(clk), .RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CMP_GND_P(gp), .CMP_GND_N(gn),
        .CMP_VS(vs), .CMP_SLOAD(sl), .CMP_OPEN(op), .CMP_OFFSET(ofs), .CMP_CUR_HI(cur),
        .PROT_TRIP(trip), .CH_ACTIVE(act), .TEST_PULSE(pulse), .OUT_HIZ(hiz),
        .PWR_BIAS(bias), .LINE_THR(thr));
    sods_host sods_host_inst (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("FAIL %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        sods_host_inst.xfer(1'b1, a, d, q, err);
    endtask
    task rd;
        sods_host_inst.xfer(1'b0, 8'h04, 32'h0, q, err);
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regs;
        begin
            chk({hiz, bias, pulse, act, thr}, {1'b1, 10'h0});
            wr(8'h00, 32'h0818);
            cyc(4);
            chk(thr, 4'hf);
            wr(8'h00, 32'h0810);
            cyc(4);
            chk(thr, 4'h3);
            wr(8'h00, 32'h0018);
            cyc(4);
            chk(thr, 4'h0);
            wr(8'h04, 32'h1);
            chk(err, 1'b1);
            sods_host_inst.xfer(1'b0, 8'h0c, 32'h0, q, err);
            chk(q, 32'h0);
            chk(err, 1'b1);
            wr(8'h00, 32'h1000);
            cyc(5);
            chk({pulse, bias}, 2'b01);
            wr(8'h00, 32'h0000);
            cyc(3);
            chk(hiz, 1'b1);
            $display("%0t regs done", $time);
        end
    endtask

    // Feed side is the positive output on channels 0 and 3, negative on 1 and 2.
    task t_turnon;
        begin
            gp <= 4'h3;
            sl <= 4'h1;
            vs <= 4'h6;
            gn <= 4'hc;
            op <= 4'h8;
            cyc(6);
            wr(8'h00, 32'h1040);
            cyc(3);
            chk({pulse, hiz, bias}, 3'b110);
            cyc(CYC - 10);
            chk(pulse, 1'b1);
            for (i = 0; i < 30 && bias !== 1'b1; i = i + 1) cyc(1);
            chk({pulse, hiz, bias}, 3'b001);
            {gp, gn, vs, sl, op} <= 20'h0;
            rd;
            chk(q & 32'h1f1f1f1f, 32'h0);
            rd;
            chk(q & 32'h1f1f1f1f, 32'h04030201);
            rd;
            chk(q & 32'h1f1f1f1f, 32'h04030201);
            sods_host_inst.xfer(1'b0, 8'h08, 32'h0, q, err);
            chk(q, 32'ha);
            chk(act, 4'hf);
            $display("%0t turn-on done", $time);
        end
    endtask

    task t_perm;
        begin
            vs <= 4'h1;
            op <= 4'h1;
            trip <= 4'h1;
            cyc(10);
            chk(act, 4'he);
            cyc(RCHK + CYC + 20);
            rd;
            rd;
            chk(q & 32'h5f, 32'h52);
            {trip, vs, op} <= {4'h4, 8'h0};
            cyc(8);
            chk(act[2], 1'b0);
            trip <= 4'h0;
            cyc(RCHK + 12);
            chk(act[2], 1'b1);
            for (i = 0; i < 3 * RCHK + CYC + 30 && act !== 4'hf; i = i + 1) cyc(1);
            chk(act, 4'hf);
            $display("%0t permanent done", $time);
        end
    endtask

    // Channel 0 trips throughout and channel 2 loses its offset once, after the tone pulses.
    task t_ofs_ac;
        begin
            ofs <= 4'h7;
            trip <= 4'h1;
            cyc(6);
            wr(8'h00, 32'h1460);
            for (i = 0; i < 3; i = i + 1) begin
                cur <= (i < 2) ? 4'he : 4'h6;
                cyc(6);
                cur <= 4'h0;
                cyc(6);
            end
            ofs <= 4'h3;
            cyc(6);
            ofs <= 4'h7;
            cyc(6);
            rd;
            rd;
            chk(q & 32'h24242424, 32'h24000400);
            {trip, ofs} <= 8'h0;
            $display("%0t offset and tone done", $time);
        end
    endtask

    initial begin
        cyc(16);
        rst <= 1'b0;
        t_regs;
        t_turnon;
        t_perm;
        t_ofs_ac;
        stop_test;
    end

    initial begin
        cyc(6000);
        fail_count = fail_count + 1;
        stop_test;
    end
endmodule
